// ===== dv/fdp_chk.sv
// checker: port-level properties of the floppy pin control
`timescale 1ns/100ps
`default_nettype none
module fdp_chk (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic [3:0] DACK_N,
    input wire logic       DIR_OUT,
    input wire logic       DATA_RATE_OUT,
    input wire logic       HEAD_SIDE_SELECT_N,
    input wire logic [3:0] DRQ,
    input wire logic       DMA_RD_STB
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_hd(logic [2:0] v);
        WR && ADDR == fdp_pkg::ADDR_HEAD && WDATA[3:1] == v;
    endsequence
    sequence s_wr(logic [3:0] a);
        WR && ADDR == a;
    endsequence
    AST_DIR_IN: assert property (s_hd(3'h3) |-> ##2 DIR_OUT)
        else $error("inward seek not shown");
    AST_DIR_OUT: assert property (s_hd(3'h1) |-> ##2 !DIR_OUT)
        else $error("outward seek not shown");
    AST_DIR_RW: assert property (s_hd(3'h7) |-> ##2 !DIR_OUT)
        else $error("direction active during transfer");
    AST_SIDE: assert property (s_wr(fdp_pkg::ADDR_HEAD) |-> ##2 HEAD_SIDE_SELECT_N == !$past(WDATA[0], 2))
        else $error("head side wrong");
    AST_RATE: assert property ((s_wr(fdp_pkg::ADDR_DSR) or s_wr(fdp_pkg::ADDR_CCR))
        |-> ##2 DATA_RATE_OUT == $past(WDATA[0], 2))
        else $error("rate output wrong");
    AST_DRQ_HOT: assert property ($onehot0(DRQ))
        else $error("more than one request line");
    AST_STB: assert property (DMA_RD_STB |-> $past(DACK_N, 2) != 4'hF)
        else $error("strobe without acknowledge");
    AST_RST: assert property (disable iff (1'b0) RST |=> !DIR_OUT && HEAD_SIDE_SELECT_N && DRQ == 4'h0)
        else $error("outputs active in reset");
endmodule
`default_nettype wire

// ===== dv/fdp_host_model.sv
// partner: host dma controller answering the request lines
`timescale 1ns/100ps
`default_nettype none
module fdp_host_model (
    input  wire logic       CLK,
    input  wire logic       slow,
    input  wire logic [3:0] DRQ,
    output logic      [3:0] DACK_N = 4'hF,
    output logic            IORD_N = 1'b1,
    output logic            IOWR_N = 1'b1
);
    logic [3:0] wait_cnt = 4'h0;
    // acknowledge only a standing request; slow hosts answer late and with a write
    always @(posedge CLK) begin
        if (DRQ == 4'h0) begin
            wait_cnt <= 4'h0;
            DACK_N <= 4'hF;
            IORD_N <= 1'b1;
            IOWR_N <= 1'b1;
        end else if (wait_cnt != (slow ? 4'hC : 4'h1)) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            DACK_N <= ~DRQ;
            IORD_N <= slow;
            IOWR_N <= !slow;
        end
    end
endmodule
`default_nettype wire

// ===== dv/fdp_top_tb.sv
// bench: directed scenarios for the floppy pin control
`timescale 1ns/100ps
`default_nettype none
module fdp_top_tb;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, chg = 1'b0, slow = 1'b0;
    logic [3:0] addr = 4'h0, dack_n, drq;
    logic [7:0] wdata = 8'h00, rdata, got;
    logic       iord_n, iowr_n, dir_o, rate_o, dens_o, side_n, read_gate_diag, rd_stb, wr_stb;
    logic [1:0] sel_n;
    int         fail_count = 0, comparisons = 0, cycles = 0;
    fdp_top DUT (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .DISK_CHANGE_IN(chg), .DACK_N(dack_n), .IORD_N(iord_n),
        .IOWR_N(iowr_n), .DIR_OUT(dir_o), .DRIVE_SELECT_LINES_N(sel_n), .DATA_RATE_OUT(rate_o),
        .DENSITY_SELECT_OUT(dens_o), .HEAD_SIDE_SELECT_N(side_n), .DRQ(drq),
        .READ_GATE_DIAG(read_gate_diag), .DMA_RD_STB(rd_stb), .DMA_WR_STB(wr_stb));
    fdp_host_model u_host (.CLK(clk), .slow(slow), .DRQ(drq), .DACK_N(dack_n),
        .IORD_N(iord_n), .IOWR_N(iowr_n));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic idle(input int n);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // no trailing strobe release, so writes may follow each other without a gap
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
    endtask
    task automatic rdr(input logic [3:0] a, output logic [7:0] d);
        addr <= a;
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask
    task automatic do_reset();
        rst <= 1'b1;
        idle(4);
        chk("dir", 8'h00, dir_o);
        chk("sel", 8'h03, sel_n);
        chk("side", 8'h01, side_n);
        chk("drq", 8'h00, drq);
        rst <= 1'b0;
        idle(1);
    endtask
    task automatic t_sel();
        logic [1:0] e;
        for (int f = 0; f < 2; f++) begin
            wrr(fdp_pkg::ADDR_FCFG, {f[0], 7'h00});
            for (int s = 0; s < 4; s++) begin
                wrr(fdp_pkg::ADDR_DOR, 8'(s));
                idle(3);
                e = f[0] ? ~2'(s) : (s == 0 ? 2'h2 : (s == 1 ? 2'h1 : 2'h3));
                chk("sel", 8'(e), sel_n);
            end
        end
        rdr(fdp_pkg::ADDR_DOR, got);
        chk("dor", 8'h03, got);
    endtask
    task automatic t_head();
        logic [7:0] hv[3] = '{8'h07, 8'h02, 8'h0E};
        foreach (hv[i]) begin
            wrr(fdp_pkg::ADDR_HEAD, hv[i]);
            idle(3);
            chk("dir", 8'(hv[i] == 8'h07), dir_o);
            chk("side", 8'(!hv[i][0]), side_n);
        end
    endtask
    task automatic t_rate();
        logic [1:0] r;
        for (int i = 0; i < 8; i++) begin
            r = 2'(i);
            wrr(fdp_pkg::ADDR_FCFG, {2'h0, i[2], 5'h00});
            wrr(i[0] ? fdp_pkg::ADDR_CCR : fdp_pkg::ADDR_DSR, {6'h00, ~r});
            wrr(i[0] ? fdp_pkg::ADDR_DSR : fdp_pkg::ADDR_CCR, {6'h00, r});
            idle(3);
            chk("rate", 8'(r[0]), rate_o);
            chk("dens", 8'((r == 2'h0 || r == 2'h3) ^ i[2]), dens_o);
        end
    endtask
    task automatic t_chg();
        for (int v = 1; v >= 0; v--) begin
            chg <= v[0];
            wrr(fdp_pkg::ADDR_MODE, 8'h00);
            idle(4);
            rdr(fdp_pkg::ADDR_DIN, got);
            chk("din", 8'(v[0]), 8'(got[fdp_pkg::DIN_CHG_BIT]));
            chk("read_gate_diag", 8'h00, read_gate_diag);
            wrr(fdp_pkg::ADDR_MODE, 8'h01);
            rdr(fdp_pkg::ADDR_DIN, got);
            chk("din", 8'h00, 8'(got[fdp_pkg::DIN_CHG_BIT]));
            chk("read_gate_diag", 8'(v[0]), read_gate_diag);
        end
        rdr(4'hF, got);
        chk("unmapped", 8'h00, got);
    endtask
    task automatic t_dma();
        int n;
        wrr(fdp_pkg::ADDR_DMA, 8'h04);
        idle(3);
        chk("drq", 8'h00, drq);
        wrr(fdp_pkg::ADDR_DOR, 8'h08);
        for (int c = 0; c < 4; c++) begin
            slow <= c[0];
            wrr(fdp_pkg::ADDR_DMA, 8'(4 + c));
            idle(3);
            chk("drq", 8'(1 << c), drq);
            for (n = 0; n < 40 && (c[0] ? wr_stb : rd_stb) !== 1'b1; n++) @(negedge clk);
            chk("stb", 8'h01, c[0] ? wr_stb : rd_stb);
            @(posedge clk);
            wrr(fdp_pkg::ADDR_DMA, 8'h00);
            idle(5);
        end
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        do_reset();
        t_sel();
        t_head();
        t_rate();
        t_chg();
        t_dma();
        do_reset();
        stop_test();
    end
endmodule
bind fdp_top fdp_chk u_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .DACK_N(DACK_N), .DIR_OUT(DIR_OUT), .DATA_RATE_OUT(DATA_RATE_OUT),
    .HEAD_SIDE_SELECT_N(HEAD_SIDE_SELECT_N), .DRQ(DRQ), .DMA_RD_STB(DMA_RD_STB));
`default_nettype wire

// ===== rtl/fdp_pkg.sv
// package: register map, field positions and reset values for the floppy pin control
package fdp_pkg;
    localparam logic [3:0] ADDR_DOR     = 4'h2;
    localparam logic [3:0] ADDR_DSR     = 4'h4;
    localparam logic [3:0] ADDR_DIN     = 4'h7;
    localparam logic [3:0] ADDR_CCR     = 4'h7;
    localparam logic [3:0] ADDR_FCFG    = 4'h8;
    localparam logic [3:0] ADDR_HEAD    = 4'h9;
    localparam logic [3:0] ADDR_MODE    = 4'hA;
    localparam logic [3:0] ADDR_DMA     = 4'hB;
    localparam int DOR_SEL_LSB    = 0;
    localparam int DOR_RESET_N    = 2;
    localparam int DOR_DMA_EN     = 3;
    localparam int DIN_CHG_BIT    = 7;
    localparam int FCFG_DENS_POL  = 5;
    localparam int FCFG_FOUR_DRV  = 7;
    localparam int HEAD_SIDE      = 0;
    localparam int HEAD_SEEK      = 1;
    localparam int HEAD_INWARD    = 2;
    localparam int HEAD_RW        = 3;
    localparam int MODE_READ_GATE_DIAG     = 0;
    localparam int DMA_CH_LSB     = 0;
    localparam int DMA_REQ        = 2;
    localparam logic [7:0] DOR_RESET  = 8'h00;
    localparam logic [7:0] FCFG_RESET = 8'h00;
    localparam logic [7:0] HEAD_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] DMA_RESET  = 8'h00;
    localparam logic [1:0] RATE_RESET = 2'h2;
endpackage

// ===== rtl/fdp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module fdp_sync #(
    parameter int W = 1
) (
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;
    always_ff @(posedge CLK) begin
        if (RST) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= D;
            sync_ff <= meta_ff;
        end
    end
    assign Q = sync_ff;
endmodule
`default_nettype wire

// ===== rtl/fdp_top.sv
// floppy drive pin control: drive-side outputs, disk change sense and DMA request
//
// Contract
// - during seek, direction output active steps inward, inactive steps outward.
// - direction output held inactive while a read or write is in progress.
// - two active-low drive select lines decoded from output register bits 0,1.
// - configuration bit 7 set encodes the two select lines to address four drives.
// - data rate output follows bit 0 of last written rate register.
// - disk change input sampled and readable in the digital input register.
// - mode setting reassigns disk change input as read gate diagnostic input.
// - active-high DMA request driven on one of four selectable lines.
// - density output shows high versus low rate, polarity from configuration bit 5.
// - head side output low selects side 1, inactive selects side 0.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module fdp_top (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       DISK_CHANGE_IN,
    input  wire logic [3:0] DACK_N,
    input  wire logic       IORD_N,
    input  wire logic       IOWR_N,
    output logic            DIR_OUT,
    output logic      [1:0] DRIVE_SELECT_LINES_N,
    output logic            DATA_RATE_OUT,
    output logic            DENSITY_SELECT_OUT,
    output logic            HEAD_SIDE_SELECT_N,
    output logic      [3:0] DRQ,
    output logic            READ_GATE_DIAG,
    output logic            DMA_RD_STB,
    output logic            DMA_WR_STB
);
    logic [7:0] dor_ff,  nxt_dor;
    logic [7:0] fcfg_ff, nxt_fcfg;
    logic [7:0] head_ff, nxt_head;
    logic [7:0] mode_ff, nxt_mode;
    logic [7:0] dma_ff,  nxt_dma;
    logic [1:0] rate_ff, nxt_rate;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       dir_ff, nxt_dir;
    logic [1:0] sel_ff, nxt_sel;
    logic       drate_ff, nxt_drate;
    logic       dens_ff, nxt_dens;
    logic       side_ff, nxt_side;
    logic [3:0] drq_ff, nxt_drq;
    logic       read_gate_diag_ff, nxt_read_gate_diag;
    logic       chg_s;
    logic [3:0] dack_s;
    logic       iord_s;
    logic       iowr_s;

    // pins from outside the clock domain pass two flops first
    fdp_sync #(.W(7)) u_sync (
        .CLK (CLK),
        .RST (RST),
        .D   ({DISK_CHANGE_IN, ~DACK_N, ~IORD_N, ~IOWR_N}),
        .Q   ({chg_s, dack_s, iord_s, iowr_s})
    );

    // one-hot-low drive select for two drives, binary for four drives
    function automatic logic [1:0] drv_decode(input logic [1:0] sel, input logic four);
        if (four) begin
            drv_decode = ~sel;
        end else if (sel == 2'h0) begin
            drv_decode = 2'h2;
        end else if (sel == 2'h1) begin
            drv_decode = 2'h1;
        end else begin
            drv_decode = 2'h3;
        end
    endfunction

    always_comb begin
        nxt_dor  = dor_ff;
        nxt_fcfg = fcfg_ff;
        nxt_head = head_ff;
        nxt_mode = mode_ff;
        nxt_dma  = dma_ff;
        nxt_rate = rate_ff;
        if (WR) begin
            if (ADDR == fdp_pkg::ADDR_DOR) begin
                nxt_dor = WDATA;
            end else if (ADDR == fdp_pkg::ADDR_DSR) begin
                nxt_rate = WDATA[1:0];
            end else if (ADDR == fdp_pkg::ADDR_CCR) begin
                nxt_rate = WDATA[1:0];
            end else if (ADDR == fdp_pkg::ADDR_FCFG) begin
                nxt_fcfg = WDATA;
            end else if (ADDR == fdp_pkg::ADDR_HEAD) begin
                nxt_head = WDATA;
            end else if (ADDR == fdp_pkg::ADDR_MODE) begin
                nxt_mode = WDATA;
            end else if (ADDR == fdp_pkg::ADDR_DMA) begin
                nxt_dma = WDATA;
            end
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (RD) begin
            if (ADDR == fdp_pkg::ADDR_DOR) begin
                nxt_rdata = dor_ff;
            end else if (ADDR == fdp_pkg::ADDR_DIN) begin
                // change bit reads zero while the pin serves as read gate
                nxt_rdata = {chg_s & ~mode_ff[fdp_pkg::MODE_READ_GATE_DIAG], 7'h00};
            end else if (ADDR == fdp_pkg::ADDR_DSR) begin
                nxt_rdata = {6'h00, rate_ff};
            end else if (ADDR == fdp_pkg::ADDR_FCFG) begin
                nxt_rdata = fcfg_ff;
            end else if (ADDR == fdp_pkg::ADDR_HEAD) begin
                nxt_rdata = head_ff;
            end else if (ADDR == fdp_pkg::ADDR_MODE) begin
                nxt_rdata = mode_ff;
            end else if (ADDR == fdp_pkg::ADDR_DMA) begin
                nxt_rdata = {dma_ff[7:4], dack_s[dma_ff[1:0]], dma_ff[2:0]};
            end
        end
    end

    always_comb begin
        logic hi_rate;
        hi_rate = (rate_ff == 2'h0) | (rate_ff == 2'h3);
        // a read or write overrides any seek direction
        nxt_dir = head_ff[fdp_pkg::HEAD_SEEK] & ~head_ff[fdp_pkg::HEAD_RW]
                  & head_ff[fdp_pkg::HEAD_INWARD];
        nxt_sel = drv_decode(dor_ff[fdp_pkg::DOR_SEL_LSB +: 2],
                             fcfg_ff[fdp_pkg::FCFG_FOUR_DRV]);
        nxt_drate = rate_ff[0];
        // polarity clear drives high on a high rate, set inverts it
        nxt_dens = hi_rate ^ fcfg_ff[fdp_pkg::FCFG_DENS_POL];
        nxt_side = ~head_ff[fdp_pkg::HEAD_SIDE];
        nxt_drq = 4'h0;
        if (dma_ff[fdp_pkg::DMA_REQ] & dor_ff[fdp_pkg::DOR_DMA_EN]) begin
            nxt_drq[dma_ff[fdp_pkg::DMA_CH_LSB +: 2]] = 1'b1;
        end
        nxt_read_gate_diag = chg_s & mode_ff[fdp_pkg::MODE_READ_GATE_DIAG];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dor_ff   <= fdp_pkg::DOR_RESET;
            fcfg_ff  <= fdp_pkg::FCFG_RESET;
            head_ff  <= fdp_pkg::HEAD_RESET;
            mode_ff  <= fdp_pkg::MODE_RESET;
            dma_ff   <= fdp_pkg::DMA_RESET;
            rate_ff  <= fdp_pkg::RATE_RESET;
            rdata_ff <= 8'h00;
            dir_ff   <= 1'b0;
            sel_ff   <= 2'h3;
            drate_ff <= 1'b0;
            dens_ff  <= 1'b0;
            side_ff  <= 1'b1;
            drq_ff   <= 4'h0;
            read_gate_diag_ff <= 1'b0;
        end else begin
            dor_ff   <= nxt_dor;
            fcfg_ff  <= nxt_fcfg;
            head_ff  <= nxt_head;
            mode_ff  <= nxt_mode;
            dma_ff   <= nxt_dma;
            rate_ff  <= nxt_rate;
            rdata_ff <= nxt_rdata;
            dir_ff   <= nxt_dir;
            sel_ff   <= nxt_sel;
            drate_ff <= nxt_drate;
            dens_ff  <= nxt_dens;
            side_ff  <= nxt_side;
            drq_ff   <= nxt_drq;
            read_gate_diag_ff <= nxt_read_gate_diag;
        end
    end

    logic ack_sel;
    assign ack_sel = dack_s[dma_ff[fdp_pkg::DMA_CH_LSB +: 2]];
    // strobes pass only under acknowledge of the chosen channel
    assign DMA_RD_STB = ack_sel & iord_s & drq_ff != 4'h0;
    assign DMA_WR_STB = ack_sel & iowr_s & drq_ff != 4'h0;

    assign RDATA                = rdata_ff;
    assign DIR_OUT              = dir_ff;
    assign DRIVE_SELECT_LINES_N = sel_ff;
    assign DATA_RATE_OUT        = drate_ff;
    assign DENSITY_SELECT_OUT   = dens_ff;
    assign HEAD_SIDE_SELECT_N   = side_ff;
    assign DRQ                  = drq_ff;
    assign READ_GATE_DIAG       = read_gate_diag_ff;
endmodule
`default_nettype wire
